// file: hw/stop_seq_pkg.sv
package stop_seq_pkg;

  // Operation kinds reported by the motion core.
  typedef enum logic [2:0] {
    OP_IDLE = 3'b000,
    OP_HOMING = 3'b001,
    OP_INTERRUPT = 3'b010,
    OP_TABLE = 3'b011,
    OP_IMMEDIATE = 3'b100,
    OP_SPEED = 3'b101,
    OP_PULSE = 3'b110
  } op_kind_t;

  // Stop methods handed to the motion core.
  typedef enum logic [2:0] {
    STOP_NONE = 3'b000,
    STOP_DECEL = 3'b001,
    STOP_TORQUE = 3'b010,
    STOP_COAST = 3'b011,
    STOP_HOLD = 3'b100
  } stop_method_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_PAUSE = 3'b001,
    ST_STOPPING = 3'b010,
    ST_STOPPED = 3'b011,
    ST_COAST = 3'b100
  } seq_state_t;

  // Drive-disable and alarm action encodings.
  localparam logic [1:0] ACT_DECEL = 2'h0;
  localparam logic [1:0] ACT_TORQUE = 2'h1;
  localparam logic [1:0] ACT_COAST = 2'h2;

  // Torque and time field widths.
  localparam int TQ_W = 10;
  localparam int TIME_W = 16;
  localparam int POS_W = 32;

  // Reset values.
  localparam logic [TQ_W-1:0] TQ_RESET = 10'h000;
  localparam logic [TIME_W-1:0] TIME_RESET = 16'h0000;

  // Synchroniser depth for pin inputs.
  localparam int SYNC_DEPTH = 3;

endpackage

// file: hw/pin_sync.sv
`timescale 1ns/10ps
module pin_sync
  import stop_seq_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Pin and filtered level.
  input wire logic pin,
  output logic level
);

  logic [SYNC_DEPTH-1:0] stage;
  logic [SYNC_DEPTH-1:0] next_stage;
  logic next_level;

  // Shift the pin in; accept a change once the last two stages agree.
  always_comb begin
    next_stage = {stage[SYNC_DEPTH-2:0], pin};
    next_level = level;
    if (stage[SYNC_DEPTH-1] == stage[SYNC_DEPTH-2]) begin
      next_level = stage[SYNC_DEPTH-1];
    end
  end

  // Register the stages.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stage <= {SYNC_DEPTH{RESET_LEVEL}};
      level <= RESET_LEVEL;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

endmodule

// file: hw/torque_pick.sv
`timescale 1ns/10ps
module torque_pick
  import stop_seq_pkg::*;
(
  // Candidate limits.
  input wire logic [TQ_W-1:0] base_limit,
  input wire logic [TQ_W-1:0] dir_limit,
  // Chosen limit.
  output logic [TQ_W-1:0] limit
);

  // The smaller of the two limits brakes the motor.
  always_comb begin
    limit = (dir_limit < base_limit) ? dir_limit : base_limit;
  end

endmodule

// file: hw/motion_stop_interrupt_sequencer.sv
`timescale 1ns/10ps
// Function
// - Enable drop while turning stops per disable action
// - Immediate disable action brakes at third limit
// - Coast disable action removes torque
// - Smaller forward/reverse limit overrides third limit
// - Overtravel stops immediately at third limit
// - Homing reverse overtravel: no flags, homing action
// - Forced stop brakes, then holds zero, discards position
// - Pause decelerates positioning kinds and holds
// - Pause release resumes without new start
// - In-position stays low during pause
// - Pause ramps use selected or entry times
// - Cancel decelerates over configured time
// - Cancel held refuses positioning starts
// - Cancel also acts in speed, pulse
// - Deviation clear brakes at selected limit
// - Level form holds zero, discards position
// - Free-run cuts power stage, aborts
// - Alarm uses alarm action; serious coasts
// - Limiter target cancels; flag after stop
// - Pulse position at limiter stops there
module motion_stop_interrupt_sequencer
  import stop_seq_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Sequence pins from the host, unsynchronised.
  input wire logic drive_enable_input,
  input wire logic positive_overtravel_input,
  input wire logic negative_overtravel_input,
  input wire logic forced_stop_input,
  input wire logic pause_input,
  input wire logic cancel_input,
  input wire logic deviation_clear_input,
  input wire logic free_run_input,
  input wire logic accel_select_input,
  // Motion core state, same clock.
  input wire logic motor_turning,
  input wire logic motor_stopped,
  input wire logic [2:0] op_kind,
  input wire logic start_request,
  input wire logic at_target,
  input wire logic homing_reverse_ot,
  input wire logic soft_ot_positive,
  input wire logic soft_ot_negative,
  input wire logic limit_hit_positive,
  input wire logic limit_hit_negative,
  input wire logic alarm,
  input wire logic alarm_serious,
  input wire logic use_entry_times,
  input wire logic [TIME_W-1:0] entry_accel_time,
  input wire logic [TIME_W-1:0] entry_decel_time,
  // Configuration settings.
  input wire logic [1:0] drive_disable_action_setting,
  input wire logic [1:0] alarm_stop_action_setting,
  input wire logic [1:0] homing_overtravel_action_setting,
  input wire logic deviation_clear_form_setting,
  input wire logic [TQ_W-1:0] third_torque_limit_setting,
  input wire logic [TQ_W-1:0] forward_torque_limit_setting,
  input wire logic [TQ_W-1:0] reverse_torque_limit_setting,
  input wire logic [TQ_W-1:0] selected_torque_limit,
  input wire logic [TQ_W-1:0] pulse_limiter_torque_setting,
  input wire logic [TIME_W-1:0] accel_time_setting_first,
  input wire logic [TIME_W-1:0] accel_time_setting_second,
  input wire logic [TIME_W-1:0] decel_time_setting_first,
  input wire logic [TIME_W-1:0] decel_time_setting_second,
  // Commands to the motion core.
  output logic [2:0] stop_method,
  output logic [TQ_W-1:0] stop_torque,
  output logic [TIME_W-1:0] ramp_accel_time,
  output logic [TIME_W-1:0] ramp_decel_time,
  output logic abort_operation,
  output logic hold_zero_speed,
  output logic discard_position,
  output logic power_stage_enable,
  output logic start_accept,
  output logic paused,
  // Status outputs.
  output logic in_position_output,
  output logic positive_ot_detect,
  output logic negative_ot_detect,
  output logic positive_limiter_detect,
  output logic negative_limiter_detect
);

  logic en_s, pot_s, not_s, emg_s, pause_s, cancel_s, dclr_s, free_s, acc_s;
  logic [TQ_W-1:0] fwd_third, third_lim;
  seq_state_t state, next_state;
  logic [2:0] next_stop_method;
  logic [TQ_W-1:0] next_stop_torque;
  logic [TIME_W-1:0] next_ramp_accel_time, next_ramp_decel_time;
  logic next_abort_operation, next_hold_zero_speed, next_discard_position;
  logic next_power_stage_enable, next_start_accept, next_paused;
  logic next_in_position_output, next_positive_ot_detect, next_negative_ot_detect;
  logic next_positive_limiter_detect, next_negative_limiter_detect;
  logic lim_pend_pos, lim_pend_neg, next_lim_pend_pos, next_lim_pend_neg;
  logic pausable, homing_rev, hw_ot_pos, hw_ot_neg, any_ot;
  logic dclr_prev, next_dclr_prev, dclr_event;

  // Overtravel and forced-stop pins idle high (closed contact); enable and the rest reset low.
  pin_sync #(.RESET_LEVEL(1'b0)) u_en (.sys_clk(sys_clk), .resetn(resetn),
    .pin(drive_enable_input), .level(en_s));
  pin_sync #(.RESET_LEVEL(1'b1)) u_pot (.sys_clk(sys_clk), .resetn(resetn),
    .pin(positive_overtravel_input), .level(pot_s));
  pin_sync #(.RESET_LEVEL(1'b1)) u_not (.sys_clk(sys_clk), .resetn(resetn),
    .pin(negative_overtravel_input), .level(not_s));
  pin_sync #(.RESET_LEVEL(1'b1)) u_emg (.sys_clk(sys_clk), .resetn(resetn),
    .pin(forced_stop_input), .level(emg_s));
  pin_sync #(.RESET_LEVEL(1'b0)) u_pause (.sys_clk(sys_clk), .resetn(resetn),
    .pin(pause_input), .level(pause_s));
  pin_sync #(.RESET_LEVEL(1'b0)) u_cancel (.sys_clk(sys_clk), .resetn(resetn),
    .pin(cancel_input), .level(cancel_s));
  pin_sync #(.RESET_LEVEL(1'b0)) u_dclr (.sys_clk(sys_clk), .resetn(resetn),
    .pin(deviation_clear_input), .level(dclr_s));
  pin_sync #(.RESET_LEVEL(1'b0)) u_free (.sys_clk(sys_clk), .resetn(resetn),
    .pin(free_run_input), .level(free_s));
  pin_sync #(.RESET_LEVEL(1'b0)) u_acc (.sys_clk(sys_clk), .resetn(resetn),
    .pin(accel_select_input), .level(acc_s));

  // Third limit clipped by the smaller of forward and reverse limits.
  torque_pick u_tq_fwd (.base_limit(third_torque_limit_setting),
    .dir_limit(forward_torque_limit_setting), .limit(fwd_third));
  torque_pick u_tq_rev (.base_limit(fwd_third),
    .dir_limit(reverse_torque_limit_setting), .limit(third_lim));

  // Qualifiers shared by the next-state logic.
  always_comb begin
    pausable = (op_kind == OP_HOMING) || (op_kind == OP_INTERRUPT) ||
               (op_kind == OP_TABLE) || (op_kind == OP_IMMEDIATE);
    homing_rev = (op_kind == OP_HOMING) && homing_reverse_ot;
    hw_ot_pos = !pot_s || soft_ot_positive;
    hw_ot_neg = !not_s || soft_ot_negative;
    any_ot = hw_ot_pos || hw_ot_neg;
    dclr_event = deviation_clear_form_setting ? dclr_s : (dclr_s && !dclr_prev);
  end

  // Pick the most severe active stop condition and the outputs it demands.
  always_comb begin
    next_state = state;
    next_stop_method = STOP_NONE;
    next_stop_torque = third_lim;
    next_abort_operation = 1'b0;
    next_hold_zero_speed = 1'b0;
    next_discard_position = 1'b0;
    next_power_stage_enable = 1'b1;
    next_paused = 1'b0;
    next_dclr_prev = dclr_s;
    next_lim_pend_pos = lim_pend_pos;
    next_lim_pend_neg = lim_pend_neg;
    next_positive_ot_detect = hw_ot_pos && !homing_rev;
    next_negative_ot_detect = hw_ot_neg && !homing_rev;
    next_positive_limiter_detect = 1'b0;
    next_negative_limiter_detect = 1'b0;
    next_ramp_accel_time = acc_s ? accel_time_setting_second : accel_time_setting_first;
    next_ramp_decel_time = acc_s ? decel_time_setting_second : decel_time_setting_first;
    if (use_entry_times) begin
      next_ramp_accel_time = entry_accel_time;
      next_ramp_decel_time = entry_decel_time;
    end
    if (alarm || free_s) begin
      // Alarm and free-run outrank everything.
      next_abort_operation = 1'b1;
      if (free_s || alarm_serious || alarm_stop_action_setting == ACT_COAST) begin
        next_stop_method = STOP_COAST;
        next_power_stage_enable = 1'b0;
        next_state = ST_COAST;
      end else begin
        next_stop_method = (alarm_stop_action_setting == ACT_TORQUE) ?
                           STOP_TORQUE : STOP_DECEL;
        next_state = ST_STOPPING;
      end
    end else if (!emg_s) begin
      // Open contact means forced stop.
      next_abort_operation = 1'b1;
      next_stop_method = motor_turning ? STOP_TORQUE : STOP_HOLD;
      next_hold_zero_speed = 1'b1;
      next_discard_position = 1'b1;
      next_state = ST_STOPPING;
    end else if (any_ot) begin
      next_abort_operation = 1'b1;
      if (homing_rev) begin
        next_stop_method = (homing_overtravel_action_setting == ACT_DECEL) ?
                           STOP_DECEL : STOP_TORQUE;
      end else begin
        next_stop_method = STOP_TORQUE;
      end
      next_state = ST_STOPPING;
    end else if (!en_s && (motor_turning || state != ST_RUN)) begin
      next_abort_operation = 1'b1;
      if (drive_disable_action_setting == ACT_COAST) begin
        next_stop_method = STOP_COAST;
        next_power_stage_enable = 1'b0;
      end else if (drive_disable_action_setting == ACT_TORQUE) begin
        next_stop_method = STOP_TORQUE;
      end else begin
        next_stop_method = STOP_DECEL;
      end
      next_state = ST_STOPPING;
    end else if (dclr_event && (motor_turning || deviation_clear_form_setting)) begin
      next_abort_operation = 1'b1;
      next_stop_method = STOP_TORQUE;
      next_stop_torque = selected_torque_limit;
      next_hold_zero_speed = deviation_clear_form_setting;
      next_discard_position = deviation_clear_form_setting;
      next_state = ST_STOPPING;
    end else if (cancel_s && motor_turning) begin
      next_abort_operation = 1'b1;
      next_stop_method = STOP_DECEL;
      next_state = ST_STOPPING;
    end else if ((limit_hit_positive || limit_hit_negative) && motor_turning) begin
      next_abort_operation = 1'b1;
      next_stop_method = (op_kind == OP_PULSE) ? STOP_TORQUE : STOP_DECEL;
      if (op_kind == OP_PULSE) begin
        next_stop_torque = selected_torque_limit;
      end
      next_lim_pend_pos = lim_pend_pos || limit_hit_positive;
      next_lim_pend_neg = lim_pend_neg || limit_hit_negative;
      next_state = ST_STOPPING;
    end else if (pause_s && pausable) begin
      next_stop_method = motor_turning ? STOP_DECEL : STOP_HOLD;
      next_paused = 1'b1;
      next_state = ST_PAUSE;
    end else begin
      // Nothing active: a pause resumes by itself, a stop settles.
      case (state)
        ST_PAUSE: next_state = ST_RUN;
        ST_STOPPING: next_state = motor_stopped ? ST_STOPPED : ST_STOPPING;
        ST_COAST: next_state = motor_stopped ? ST_STOPPED : ST_COAST;
        ST_STOPPED: next_state = ST_RUN;
        default: next_state = ST_RUN;
      endcase
      if (state == ST_STOPPING) begin
        next_stop_method = STOP_DECEL;
      end
    end
    // Limiter flags rise only once the motor is at rest.
    if (motor_stopped && (lim_pend_pos || lim_pend_neg)) begin
      next_positive_limiter_detect = lim_pend_pos;
      next_negative_limiter_detect = lim_pend_neg;
      // A fresh hit in the same cycle outranks the clear by a new start.
      if (start_request && !next_abort_operation) begin
        next_lim_pend_pos = 1'b0;
        next_lim_pend_neg = 1'b0;
      end
    end
    next_start_accept = start_request && !(cancel_s && pausable) && !next_abort_operation &&
                        !next_paused;
    next_in_position_output = at_target && motor_stopped && !next_paused &&
                              !pause_s;
  end

  // Register every output and state.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= ST_RUN;
      stop_method <= STOP_NONE;
      stop_torque <= TQ_RESET;
      ramp_accel_time <= TIME_RESET;
      ramp_decel_time <= TIME_RESET;
      abort_operation <= 1'b0;
      hold_zero_speed <= 1'b0;
      discard_position <= 1'b0;
      power_stage_enable <= 1'b0;
      start_accept <= 1'b0;
      paused <= 1'b0;
      in_position_output <= 1'b0;
      positive_ot_detect <= 1'b0;
      negative_ot_detect <= 1'b0;
      positive_limiter_detect <= 1'b0;
      negative_limiter_detect <= 1'b0;
      lim_pend_pos <= 1'b0;
      lim_pend_neg <= 1'b0;
      dclr_prev <= 1'b0;
    end else begin
      state <= next_state;
      stop_method <= next_stop_method;
      stop_torque <= next_stop_torque;
      ramp_accel_time <= next_ramp_accel_time;
      ramp_decel_time <= next_ramp_decel_time;
      abort_operation <= next_abort_operation;
      hold_zero_speed <= next_hold_zero_speed;
      discard_position <= next_discard_position;
      power_stage_enable <= next_power_stage_enable;
      start_accept <= next_start_accept;
      paused <= next_paused;
      in_position_output <= next_in_position_output;
      positive_ot_detect <= next_positive_ot_detect;
      negative_ot_detect <= next_negative_ot_detect;
      positive_limiter_detect <= next_positive_limiter_detect;
      negative_limiter_detect <= next_negative_limiter_detect;
      lim_pend_pos <= next_lim_pend_pos;
      lim_pend_neg <= next_lim_pend_neg;
      dclr_prev <= next_dclr_prev;
    end
  end

  // Checks on the registered outputs, the state and the clipped third limit.
  pause_inpos_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    paused |-> !in_position_output) else $error("in-position high in pause");
  free_power_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(free_s) |=> !power_stage_enable && abort_operation)
    else $error("free-run left power on");
  emg_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !emg_s && !alarm && !free_s |=> hold_zero_speed && discard_position)
    else $error("forced stop not holding");
  ot_torque_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !alarm && !free_s && emg_s && any_ot && !homing_rev |=>
    stop_method == STOP_TORQUE && stop_torque == $past(third_lim))
    else $error("overtravel stop wrong");
  torque_min_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    third_lim <= forward_torque_limit_setting && third_lim <= reverse_torque_limit_setting &&
    third_lim <= third_torque_limit_setting) else $error("torque clip wrong");
  cancel_start_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    cancel_s && pausable |=> !start_accept) else $error("start during cancel");
  serious_coast_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    alarm && alarm_serious |=> stop_method == STOP_COAST)
    else $error("serious alarm not coasting");
  homing_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    homing_rev |=> !positive_ot_detect && !negative_ot_detect)
    else $error("homing overtravel flagged");
  limiter_rest_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(positive_limiter_detect) |-> $past(motor_stopped))
    else $error("limiter flag before stop");
  pause_resume_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    state == ST_PAUSE && !pause_s && !alarm && !free_s && emg_s && !any_ot && en_s &&
    !cancel_s && !dclr_event && !limit_hit_positive && !limit_hit_negative |=>
    state == ST_RUN) else $error("pause did not resume");
  dclr_torque_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !alarm && !free_s && emg_s && !any_ot && en_s && dclr_event &&
    (motor_turning || deviation_clear_form_setting) |=>
    stop_method == STOP_TORQUE && stop_torque == $past(selected_torque_limit))
    else $error("deviation clear stop wrong");
  cancel_decel_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !alarm && !free_s && emg_s && !any_ot && en_s && !dclr_event &&
    cancel_s && motor_turning |=> stop_method == STOP_DECEL && abort_operation)
    else $error("cancel stop wrong");
  limiter_neg_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(negative_limiter_detect) |-> $past(motor_stopped))
    else $error("negative limiter flag before stop");
  coast_power_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    stop_method == STOP_COAST |-> !power_stage_enable) else $error("coast with power on");

endmodule

// file: sim/host_model.sv
`timescale 1ns/10ps
module host_model (
  // Clock.
  input wire logic sys_clk,
  // Conditions requested by the bench, high active.
  input wire logic req_enable,
  input wire logic req_pos_ot,
  input wire logic req_neg_ot,
  input wire logic req_forced_stop,
  // Sequence pins towards the drive.
  output logic drive_enable_input,
  output logic positive_overtravel_input,
  output logic negative_overtravel_input,
  output logic forced_stop_input
);
  // Contacts start closed so that no stop is signalled at time zero.
  initial begin
    drive_enable_input = 1'b0;
    positive_overtravel_input = 1'b1;
    negative_overtravel_input = 1'b1;
    forced_stop_input = 1'b1;
  end

  // Pins move just after the edge; a stop condition opens its contact.
  always @(posedge sys_clk) begin
    drive_enable_input <= req_enable;
    positive_overtravel_input <= ~req_pos_ot;
    negative_overtravel_input <= ~req_neg_ot;
    forced_stop_input <= ~req_forced_stop;
  end
endmodule

// file: sim/motion_stop_interrupt_sequencer_tb.sv
`timescale 1ns/10ps
module motion_stop_interrupt_sequencer_tb;
  import stop_seq_pkg::*;

  // Clock, reset and requests to the host model.
  logic sys_clk = 1'b0, resetn = 1'b0;
  logic req_enable = 1'b1, req_pos_ot = 1'b0, req_neg_ot = 1'b0, req_forced_stop = 1'b0;
  logic drive_enable_input, positive_overtravel_input, negative_overtravel_input;
  logic forced_stop_input;
  // Design inputs with their time-zero values.
  logic pause_input = 1'b0, cancel_input = 1'b0, deviation_clear_input = 1'b0;
  logic free_run_input = 1'b0, accel_select_input = 1'b0, motor_turning = 1'b1;
  logic motor_stopped = 1'b0, start_request = 1'b0, at_target = 1'b0;
  logic homing_reverse_ot = 1'b0, soft_ot_positive = 1'b0, soft_ot_negative = 1'b0;
  logic limit_hit_positive = 1'b0, limit_hit_negative = 1'b0, alarm = 1'b0;
  logic alarm_serious = 1'b0, use_entry_times = 1'b0, deviation_clear_form_setting = 1'b1;
  logic [2:0] op_kind = OP_TABLE;
  logic [1:0] drive_disable_action_setting = ACT_DECEL, alarm_stop_action_setting = ACT_TORQUE;
  logic [1:0] homing_overtravel_action_setting = ACT_DECEL;
  logic [TQ_W-1:0] third_torque_limit_setting = 10'h100, forward_torque_limit_setting = 10'h080;
  logic [TQ_W-1:0] reverse_torque_limit_setting = 10'h080, selected_torque_limit = 10'h3ff;
  logic [TQ_W-1:0] pulse_limiter_torque_setting = 10'h000;
  logic [TIME_W-1:0] entry_accel_time = 16'h0055, entry_decel_time = 16'h0066;
  logic [TIME_W-1:0] accel_time_setting_first = 16'h0011, accel_time_setting_second = 16'h0022;
  logic [TIME_W-1:0] decel_time_setting_first = 16'h0033, decel_time_setting_second = 16'h0044;
  // Design outputs.
  logic [2:0] stop_method;
  logic [TQ_W-1:0] stop_torque;
  logic [TIME_W-1:0] ramp_accel_time, ramp_decel_time;
  logic abort_operation, hold_zero_speed, discard_position, power_stage_enable, start_accept;
  logic paused, in_position_output, positive_ot_detect, negative_ot_detect;
  logic positive_limiter_detect, negative_limiter_detect;
  int fails = 0, checked = 0;
  stop_method_t disable_m [3] = '{STOP_DECEL, STOP_TORQUE, STOP_COAST};

  host_model host (.*);
  motion_stop_interrupt_sequencer DUT (.*);

  // Free-running 125 MHz clock.
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Lets n edges pass and samples just after the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Puts the moving baseline back; pin paths need several edges to settle.
  task automatic restore();
    @(posedge sys_clk);
    req_enable <= 1'b1;
    req_pos_ot <= 1'b0;
    req_neg_ot <= 1'b0;
    req_forced_stop <= 1'b0;
    pause_input <= 1'b0;
    cancel_input <= 1'b0;
    deviation_clear_input <= 1'b0;
    free_run_input <= 1'b0;
    alarm <= 1'b0;
    alarm_serious <= 1'b0;
    motor_turning <= 1'b1;
    motor_stopped <= 1'b0;
    op_kind <= OP_TABLE;
    homing_reverse_ot <= 1'b0;
    limit_hit_positive <= 1'b0;
    start_request <= 1'b0;
    use_entry_times <= 1'b0;
    deviation_clear_form_setting <= 1'b1;
    third_torque_limit_setting <= 10'h100;
    cyc(8);
  endtask

  // Free-run wins over a forced stop raised at the same time.
  task automatic free_run_test();
    @(posedge sys_clk);
    free_run_input <= 1'b1;
    req_forced_stop <= 1'b1;
    cyc(6);
    chk(16'(power_stage_enable), 16'h0000);
    chk(16'(stop_method), 16'(STOP_COAST));
    chk(16'(abort_operation), 16'h0001);
    restore();
  endtask

  // Forced stop brakes at the smaller direction limit, then holds at rest.
  task automatic forced_stop_test();
    @(posedge sys_clk);
    req_forced_stop <= 1'b1;
    cyc(6);
    chk(16'(stop_method), 16'(STOP_TORQUE));
    chk(16'(stop_torque), 16'h0080);
    @(posedge sys_clk);
    motor_turning <= 1'b0;
    motor_stopped <= 1'b1;
    cyc(3);
    chk(16'(hold_zero_speed), 16'h0001);
    chk(16'(discard_position), 16'h0001);
    restore();
  endtask

  // Every drive-disable action, with the third limit below the direction limits.
  task automatic disable_test();
    for (int a = 0; a < 3; a++) begin
      @(posedge sys_clk);
      drive_disable_action_setting <= 2'(a);
      third_torque_limit_setting <= 10'h040;
      req_enable <= 1'b0;
      cyc(6);
      chk(16'(stop_method), 16'(disable_m[a]));
      chk(16'(abort_operation), 16'h0001);
      if (a == 1) begin
        chk(16'(stop_torque), 16'h0040);
      end
      restore();
    end
  endtask

  // Pause during homing stops, keeps in-position low and resumes by itself.
  task automatic pause_test();
    @(posedge sys_clk);
    op_kind <= OP_HOMING;
    pause_input <= 1'b1;
    accel_select_input <= 1'b1;
    at_target <= 1'b1;
    cyc(6);
    chk(16'(paused), 16'h0001);
    chk(16'(stop_method), 16'(STOP_DECEL));
    chk(ramp_accel_time, 16'h0022);
    chk(ramp_decel_time, 16'h0044);
    @(posedge sys_clk);
    motor_turning <= 1'b0;
    motor_stopped <= 1'b1;
    use_entry_times <= 1'b1;
    cyc(3);
    chk(16'(in_position_output), 16'h0000);
    chk(ramp_decel_time, 16'h0066);
    @(posedge sys_clk);
    pause_input <= 1'b0;
    cyc(6);
    chk(16'(paused), 16'h0000);
    chk(16'(abort_operation), 16'h0000);
    chk(16'(in_position_output), 16'h0001);
    restore();
  endtask

  // Cancel in table and speed operation; starts refused only while it stands.
  task automatic cancel_test();
    @(posedge sys_clk);
    cancel_input <= 1'b1;
    op_kind <= OP_SPEED;
    cyc(6);
    chk(16'(abort_operation), 16'h0001);
    @(posedge sys_clk);
    op_kind <= OP_TABLE;
    cyc(2);
    chk(16'(stop_method), 16'(STOP_DECEL));
    @(posedge sys_clk);
    motor_turning <= 1'b0;
    motor_stopped <= 1'b1;
    start_request <= 1'b1;
    cyc(3);
    chk(16'(start_accept), 16'h0000);
    @(posedge sys_clk);
    cancel_input <= 1'b0;
    cyc(6);
    chk(16'(start_accept), 16'h0001);
    restore();
  endtask

  // Alarm action, forced to coast for a serious alarm.
  task automatic alarm_test();
    @(posedge sys_clk);
    alarm <= 1'b1;
    alarm_serious <= 1'b1;
    cyc(3);
    chk(16'(stop_method), 16'(STOP_COAST));
    @(posedge sys_clk);
    alarm_serious <= 1'b0;
    cyc(3);
    chk(16'(stop_method), 16'(STOP_TORQUE));
    restore();
  endtask

  // Overtravel flags and braking, then silent overtravel in reverse homing.
  task automatic ot_test();
    @(posedge sys_clk);
    req_pos_ot <= 1'b1;
    cyc(6);
    chk(16'(positive_ot_detect), 16'h0001);
    chk(16'(stop_method), 16'(STOP_TORQUE));
    restore();
    @(posedge sys_clk);
    op_kind <= OP_HOMING;
    homing_reverse_ot <= 1'b1;
    req_neg_ot <= 1'b1;
    cyc(6);
    chk(16'(negative_ot_detect), 16'h0000);
    chk(16'(stop_method), 16'(STOP_DECEL));
    restore();
  endtask

  // Level deviation clear brakes at the selected limit and holds.
  task automatic dev_clear_test();
    @(posedge sys_clk);
    deviation_clear_input <= 1'b1;
    cyc(6);
    chk(stop_torque, 16'h03ff);
    chk(16'(hold_zero_speed), 16'h0001);
    restore();
    // Edge form never holds zero speed.
    @(posedge sys_clk);
    deviation_clear_form_setting <= 1'b0;
    deviation_clear_input <= 1'b1;
    cyc(6);
    chk(16'(hold_zero_speed), 16'h0000);
    restore();
  endtask

  // The limiter flag waits for the motor to stop; pulse mode brakes at the selected limit.
  task automatic limiter_test();
    @(posedge sys_clk);
    op_kind <= OP_PULSE;
    limit_hit_positive <= 1'b1;
    cyc(3);
    chk(16'(positive_limiter_detect), 16'h0000);
    chk(16'(stop_method), 16'(STOP_TORQUE));
    chk(16'(stop_torque), 16'h03ff);
    @(posedge sys_clk);
    motor_turning <= 1'b0;
    motor_stopped <= 1'b1;
    cyc(3);
    chk(16'(positive_limiter_detect), 16'h0001);
    chk(16'(negative_limiter_detect), 16'h0000);
    restore();
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    restore();
    free_run_test();
    forced_stop_test();
    disable_test();
    pause_test();
    cancel_test();
    alarm_test();
    ot_test();
    dev_clear_test();
    limiter_test();
    give_verdict();
  end

  // Cuts a hang short well after the expected few hundred cycles.
  initial begin
    #20000;
    fails++;
    give_verdict();
  end
endmodule
